// ===== hdl/plb_bank.sv
// Purpose: Parameter register bank of a telephone transmission circuit.
// Assumes: Synchronous active-low reset stands for the supply monitor.
// Notes:   Serial bus slave writes parameters; APB gives status and irq.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module plb_bank
    import plb_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_ce,
    // Serial bus pins
    input  wire logic                      i_scl,
    input  wire logic                      i_sda,
    output logic                           o_sda_o,
    output logic                           o_sda_oe,
    // Measured line current
    input  wire logic [plb_pkg::W_LC-1:0]  i_line_current_code,
    // APB slave
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [plb_pkg::APB_AW-1:0] i_paddr,
    input  wire logic [31:0]               i_pwdata,
    output logic [31:0]                    o_prdata,
    output logic                           o_pready,
    output logic                           o_pslverr,
    output logic                           o_irq,
    // Line interface settings
    output logic [plb_pkg::W_DCV-1:0]      o_dc_voltage_sel,
    output logic                           o_fast_dc_start,
    output logic [plb_pkg::W_RES-1:0]      o_set_series_res,
    output logic [plb_pkg::W_RES-1:0]      o_set_parallel_res,
    output logic [plb_pkg::W_IMP-1:0]      o_set_pole_freq,
    // Sidetone balance
    output logic [plb_pkg::W_IMP-1:0]      o_sidetone_series_res,
    output logic [plb_pkg::W_IMP-1:0]      o_sidetone_parallel_res,
    output logic [plb_pkg::W_IMP-1:0]      o_sidetone_cap,
    // Sending and receiving channels
    output logic [plb_pkg::W_GAIN-1:0]     o_send_gain,
    output logic                           o_limiter_threshold_sel,
    output logic [plb_pkg::W_GAIN-1:0]     o_receive_gain,
    output logic                           o_hearing_protect_sel,
    output logic                           o_earpiece_load_sel,
    // Control
    output logic [plb_pkg::W_PD-1:0]       o_power_down_sel,
    output logic                           o_ring_detect_disable,
    output logic                           o_receive_mute,
    output logic                           o_send_mute,
    output logic                           o_dial_pulse_ctl,
    // Signal routing derived from the mutes
    output logic                           o_mic_path_en,
    output logic                           o_dtmf_to_line,
    output logic                           o_confidence_tone
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    plb_state_type   state_reg;
    logic [7:0]      sub_reg;
    logic            ack_en_reg;
    logic            tx_en_reg;
    logic            flag_reg;
    logic [7:0]      param_reg [0:PARAM_COUNT-1];
    logic [EV_W-1:0] irq_stat_reg;
    logic [EV_W-1:0] irq_en_reg;
    logic [EV_W-1:0] irq_stat_next;

    logic            phy_start;
    logic            phy_stop;
    logic            phy_rx_valid;
    logic [7:0]      phy_rx_byte;
    logic            phy_tx_load;
    logic            phy_tx_nack;
    logic            flag_next;

    ////////////////////////////////////////////////////////////////////////
    // Bit engine
    wire [7:0] status_byte = {flag_reg, 2'b00, i_line_current_code};

    plb_i2c_phy u_phy (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_scl      (i_scl),
        .i_sda      (i_sda),
        .o_sda_oe   (o_sda_oe),
        .i_ack_en   (ack_en_reg),
        .i_tx_en    (tx_en_reg),
        .i_tx_byte  (status_byte),
        .o_start    (phy_start),
        .o_stop     (phy_stop),
        .o_rx_valid (phy_rx_valid),
        .o_rx_byte  (phy_rx_byte),
        .o_tx_load  (phy_tx_load),
        .o_tx_nack  (phy_tx_nack)
    );

    // Open-drain: the pin is only ever pulled low
    assign o_sda_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Message decode
    wire addr_hit = (phy_rx_byte[7:1] == DEV_ADDR);
    wire data_in  = (state_reg == ST_DATA) & phy_rx_valid;
    wire sub_ok   = (sub_reg < 8'(PARAM_COUNT));
    wire par_we   = data_in & sub_ok;
    wire over_ev  = data_in & ~sub_ok;

    ////////////////////////////////////////////////////////////////////////
    // Message tracker
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg  <= ST_IDLE;
            sub_reg    <= 8'h00;
            ack_en_reg <= 1'b0;
            tx_en_reg  <= 1'b0;
        end else if (i_ce) begin
            if (phy_start) begin
                state_reg  <= ST_ADDR;
                ack_en_reg <= 1'b0;
                tx_en_reg  <= 1'b0;
            end else if (phy_stop) begin
                state_reg  <= ST_IDLE;
                ack_en_reg <= 1'b0;
                tx_en_reg  <= 1'b0;
            end else begin
                unique case (state_reg)
                    ST_IDLE: begin
                    end
                    ST_ADDR: begin
                        if (phy_rx_valid && addr_hit) begin
                            ack_en_reg <= 1'b1;
                            tx_en_reg  <= phy_rx_byte[0];
                            state_reg  <= phy_rx_byte[0] ? ST_READ
                                                         : ST_SUB;
                        end else if (phy_rx_valid) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_SUB: begin
                        if (phy_rx_valid) begin
                            sub_reg   <= phy_rx_byte;
                            state_reg <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (phy_rx_valid && sub_reg != SUB_LAST) begin
                            sub_reg <= sub_reg + 8'h01;
                        end
                    end
                    ST_READ: begin
                        if (phy_tx_nack) begin
                            tx_en_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parameter registers
    genvar g;
    generate
        for (g = 0; g < PARAM_COUNT; g = g + 1) begin : g_par
            wire hit = par_we & (sub_reg == 8'(g));
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    param_reg[g] <= PARAM_RESET[g];
                end else if (i_ce && hit) begin
                    param_reg[g] <= phy_rx_byte & PARAM_MASK[g];
                end
            end
        end
    endgenerate

    assign o_dc_voltage_sel = param_reg[IDX_DC][DCV_LSB +: W_DCV];
    assign o_fast_dc_start  = param_reg[IDX_DC][FAST_BIT];
    assign o_sidetone_parallel_res =
        param_reg[IDX_ST][ST_PAR_LSB +: W_IMP];
    assign o_sidetone_series_res =
        param_reg[IDX_ST][ST_SER_LSB +: W_IMP];
    assign o_sidetone_cap   = param_reg[IDX_IMP][ST_CAP_LSB +: W_IMP];
    assign o_set_series_res = param_reg[IDX_IMP][SET_SER_LSB +: W_RES];
    assign o_set_parallel_res =
        param_reg[IDX_SET][SET_PAR_LSB +: W_RES];
    assign o_set_pole_freq  = param_reg[IDX_SET][POLE_LSB +: W_IMP];
    assign o_limiter_threshold_sel = param_reg[IDX_SEND][LIM_BIT];
    assign o_send_gain      = param_reg[IDX_SEND][SGAIN_LSB +: W_GAIN];
    assign o_receive_gain   = param_reg[IDX_RECV][RGAIN_LSB +: W_GAIN];
    assign o_earpiece_load_sel = param_reg[IDX_RECV][LOAD_BIT];
    assign o_hearing_protect_sel = param_reg[IDX_RECV][HEAR_BIT];
    assign o_power_down_sel = param_reg[IDX_CTL][PD_LSB +: W_PD];
    assign o_ring_detect_disable = param_reg[IDX_CTL][RING_BIT];
    assign o_receive_mute   = param_reg[IDX_CTL][RMUTE_BIT];
    assign o_send_mute      = param_reg[IDX_CTL][SMUTE_BIT];
    assign o_dial_pulse_ctl = param_reg[IDX_CTL][DIAL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Routing from the mutes, one cycle behind the register
    wire smute = param_reg[IDX_CTL][SMUTE_BIT];
    wire rmute = param_reg[IDX_CTL][RMUTE_BIT];

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_mic_path_en     <= 1'b1;
            o_dtmf_to_line    <= 1'b0;
            o_confidence_tone <= 1'b0;
        end else if (i_ce) begin
            o_mic_path_en     <= ~smute;
            o_dtmf_to_line    <= smute;
            o_confidence_tone <= smute & rmute;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset-occurred flag; nothing but reset sets it
    // cleared when status sent
    assign flag_next = flag_reg & ~phy_tx_load;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            flag_reg <= 1'b1;
        end else if (i_ce) begin
            flag_reg <= flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire       apb_setup = i_psel & ~i_penable;
    wire       apb_wr    = i_psel & i_penable & i_pwrite & o_pready;
    wire [3:0] word      = i_paddr[5:2];
    wire       aligned   = (i_paddr[1:0] == 2'b00);
    wire       sel_stat  = (i_paddr == A_IRQ_STAT);
    wire       sel_clr   = (i_paddr == A_IRQ_CLR);
    wire       sel_en    = (i_paddr == A_IRQ_EN);
    wire       sel_sts   = (i_paddr == A_STATUS);
    wire       sel_par   = aligned & (i_paddr[7:6] == 2'b00) &
                           (word >= PAR_WORD_LO) & (word <= PAR_WORD_HI);
    wire [3:0] par_off   = word - PAR_WORD_LO;
    wire       mapped    = sel_stat | sel_clr | sel_en | sel_sts | sel_par;
    wire [7:0] par_rd    = param_reg[par_off[2:0]];

    wire [31:0] rd_mux =
        sel_stat ? {29'h0, irq_stat_reg} :
        sel_en   ? {29'h0, irq_en_reg}   :
        sel_sts  ? {24'h0, status_byte}  :
        sel_par  ? {24'h0, par_rd}       : 32'h0;

    // Zero-wait answer: data and ready are loaded in the setup cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_pready  <= apb_setup;
            o_prdata  <= apb_setup ? rd_mux : 32'h0;
            o_pslverr <= apb_setup & ~mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: new events win over a clear in the same cycle
    wire [EV_W-1:0] ev_set = {over_ev, phy_tx_load, par_we};
    wire [EV_W-1:0] ev_clr = (apb_wr && sel_clr) ? i_pwdata[EV_W-1:0]
                                                 : {EV_W{1'b0}};

    assign irq_stat_next = (irq_stat_reg & ~ev_clr) | ev_set;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_stat_reg <= {EV_W{1'b0}};
            irq_en_reg   <= {EV_W{1'b0}};
            o_irq        <= 1'b0;
        end else if (i_ce) begin
            irq_stat_reg <= irq_stat_next;
            if (apb_wr && sel_en) begin
                irq_en_reg <= i_pwdata[EV_W-1:0];
            end
            o_irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

endmodule
`default_nettype wire

// ===== hdl/plb_pkg.sv
// Purpose: Constants for the phone line parameter bank.
// Assumes: 10 MHz system clock, two-wire serial bus sampled on it.
// Notes:   Offsets are APB byte addresses.
package plb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Serial bus
    localparam logic [6:0] DEV_ADDR    = 7'h22;
    localparam int         PARAM_COUNT = 7;
    localparam logic [7:0] SUB_LAST    = 8'hff;
    localparam logic [3:0] BIT_LAST    = 4'h7;
    localparam logic [3:0] BIT_ACK     = 4'h8;
    localparam logic [3:0] BIT_DONE    = 4'h9;

    ////////////////////////////////////////////////////////////////////////
    // Field widths
    localparam int W_DCV  = 3;
    localparam int W_RES  = 3;
    localparam int W_IMP  = 4;
    localparam int W_GAIN = 6;
    localparam int W_PD   = 2;
    localparam int W_LC   = 5;

    // Field positions, per subaddress
    localparam int IDX_DC      = 0;
    localparam int DCV_LSB     = 4;
    localparam int FAST_BIT    = 0;
    localparam int IDX_ST      = 1;
    localparam int ST_PAR_LSB  = 4;
    localparam int ST_SER_LSB  = 0;
    localparam int IDX_IMP     = 2;
    localparam int ST_CAP_LSB  = 4;
    localparam int SET_SER_LSB = 0;
    localparam int IDX_SET     = 3;
    localparam int SET_PAR_LSB = 4;
    localparam int POLE_LSB    = 0;
    localparam int IDX_SEND    = 4;
    localparam int LIM_BIT     = 7;
    localparam int SGAIN_LSB   = 0;
    localparam int IDX_RECV    = 5;
    localparam int LOAD_BIT    = 7;
    localparam int HEAR_BIT    = 6;
    localparam int RGAIN_LSB   = 0;
    localparam int IDX_CTL     = 6;
    localparam int PD_LSB      = 6;
    localparam int RING_BIT    = 4;
    localparam int RMUTE_BIT   = 3;
    localparam int SMUTE_BIT   = 2;
    localparam int DIAL_BIT    = 0;
    localparam int FLAG_BIT    = 7;

    // Reset values and writable-bit masks per subaddress
    localparam logic [7:0] PARAM_RESET [0:PARAM_COUNT-1] =
        '{8'h40, 8'h00, 8'h02, 8'h33, 8'h14, 8'h8d, 8'h00};
    localparam logic [7:0] PARAM_MASK [0:PARAM_COUNT-1] =
        '{8'h71, 8'hff, 8'hf7, 8'h7f, 8'hbf, 8'hff, 8'hdd};

    ////////////////////////////////////////////////////////////////////////
    // APB map
    localparam int         APB_AW       = 8;
    localparam logic [7:0] A_IRQ_STAT   = 8'h00;
    localparam logic [7:0] A_IRQ_CLR    = 8'h04;
    localparam logic [7:0] A_IRQ_EN     = 8'h08;
    localparam logic [7:0] A_STATUS     = 8'h0c;
    localparam logic [3:0] PAR_WORD_LO  = 4'h4;
    localparam logic [3:0] PAR_WORD_HI  = 4'ha;
    localparam int         EV_W         = 3;
    localparam int         EV_WRITE     = 0;
    localparam int         EV_READ      = 1;
    localparam int         EV_OVER      = 2;

    ////////////////////////////////////////////////////////////////////////
    // Message tracker
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_SUB  = 5'b00100,
        ST_DATA = 5'b01000,
        ST_READ = 5'b10000
    } plb_state_type;

endpackage

// ===== hdl/plb_i2c_phy.sv
// Purpose: Bit level slave engine for the two-wire serial bus.
// Assumes: Bus pins synchronous to i_clk; SCL high and low for 2+ clocks.
// Notes:   Detects start/stop, shifts bytes, drives acks and read data.
`timescale 1ns/1ps
`default_nettype none
module plb_i2c_phy
    import plb_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    // Bus pins
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_oe,
    // Byte side
    input  wire logic       i_ack_en,
    input  wire logic       i_tx_en,
    input  wire logic [7:0] i_tx_byte,
    output logic            o_start,
    output logic            o_stop,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_byte,
    output logic            o_tx_load,
    output logic            o_tx_nack
);

    logic       scl_reg;
    logic       sda_reg;
    logic       scl_old_reg;
    logic       sda_old_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic       is_tx_reg;

    wire scl_rise  = scl_reg & ~scl_old_reg;
    wire scl_fall  = ~scl_reg & scl_old_reg;
    wire scl_high  = scl_reg & scl_old_reg;
    wire start_det = scl_high & sda_old_reg & ~sda_reg;
    wire stop_det  = scl_high & ~sda_old_reg & sda_reg;

    assign o_rx_byte = shift_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling and edge history
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            scl_reg     <= 1'b1;
            sda_reg     <= 1'b1;
            scl_old_reg <= 1'b1;
            sda_old_reg <= 1'b1;
        end else if (i_ce) begin
            scl_reg     <= i_scl;
            sda_reg     <= i_sda;
            scl_old_reg <= scl_reg;
            sda_old_reg <= sda_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte framing; rises shift in, falls change what we drive
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_reg    <= 4'h0;
            shift_reg  <= 8'h00;
            is_tx_reg  <= 1'b0;
            o_sda_oe   <= 1'b0;
            o_start    <= 1'b0;
            o_stop     <= 1'b0;
            o_rx_valid <= 1'b0;
            o_tx_load  <= 1'b0;
            o_tx_nack  <= 1'b0;
        end else if (i_ce) begin
            o_start    <= start_det;
            o_stop     <= stop_det & ~start_det;
            o_rx_valid <= 1'b0;
            o_tx_load  <= 1'b0;
            o_tx_nack  <= 1'b0;
            if (start_det || stop_det) begin
                cnt_reg   <= 4'h0;
                is_tx_reg <= 1'b0;
                o_sda_oe  <= 1'b0;
            end else if (scl_rise && cnt_reg != BIT_DONE) begin
                shift_reg  <= {shift_reg[6:0], sda_reg};
                o_rx_valid <= (cnt_reg == BIT_LAST) & ~is_tx_reg;
                o_tx_nack  <= (cnt_reg == BIT_ACK) & is_tx_reg & sda_reg;
                cnt_reg    <= cnt_reg + 4'h1;
            end else if (scl_fall) begin
                if (cnt_reg == BIT_ACK) begin
                    // Ack slot: receiver pulls low, sender lets go
                    o_sda_oe <= ~is_tx_reg & i_ack_en;
                end else if (cnt_reg == BIT_DONE) begin
                    cnt_reg   <= 4'h0;
                    is_tx_reg <= i_tx_en;
                    o_tx_load <= i_tx_en;
                    if (i_tx_en) begin
                        shift_reg <= i_tx_byte;
                    end
                    o_sda_oe <= i_tx_en & ~i_tx_byte[7];
                end else if (is_tx_reg) begin
                    o_sda_oe <= ~shift_reg[7];
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== testbench/plb_bank_chk.sv
// Purpose: Port checks of the parameter bank.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound into every plb_bank.
`timescale 1ns/1ps
`default_nettype none
module plb_bank_chk
    import plb_pkg::*;
(
    // Clock, reset, bus pins
    input wire logic i_clk, i_rst_n, i_scl, o_sda_oe,
    // APB
    input wire logic i_psel, i_penable, o_pready, o_pslverr,
    input wire logic [plb_pkg::APB_AW-1:0] i_paddr,
    // Parameters and routing
    input wire logic [plb_pkg::W_GAIN-1:0] o_send_gain, o_receive_gain,
    input wire logic o_earpiece_load_sel, o_send_mute, o_receive_mute,
    input wire logic o_mic_path_en, o_dtmf_to_line, o_confidence_tone
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic bad = i_paddr > 8'h28 || i_paddr[1:0] != 2'h0;
    sequence setup_s;
        i_psel && !i_penable;
    endsequence
    sequence pulse_s;
        o_pready ##1 !o_pready;
    endsequence
    ready_pulse_a: assert property (setup_s |=> pulse_s)
        else $error("pready is not a one cycle answer");
    bad_addr_a: assert property (i_psel && !i_penable && bad |=> o_pslverr)
        else $error("unmapped address not refused");
    good_addr_a: assert property (i_psel && !i_penable && !bad |=> !o_pslverr)
        else $error("mapped address refused");
    reset_val_a: assert property ($rose(i_rst_n) |->
        o_earpiece_load_sel && o_receive_gain == 6'h0d && !o_send_mute)
        else $error("wrong value after reset");
    mic_route_a: assert property (
        o_mic_path_en != o_dtmf_to_line && o_dtmf_to_line == $past(o_send_mute))
        else $error("send mute routing wrong");
    tone_route_a: assert property (
        o_confidence_tone == ($past(o_send_mute) && $past(o_receive_mute)))
        else $error("confidence tone routing wrong");
    gain_upd_a: assert property (
        $changed(o_send_gain) || $changed(o_receive_gain) |-> i_scl)
        else $error("gain changed outside a data bit");
    ack_edge_a: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data line moved while clock high");
endmodule
bind plb_bank plb_bank_chk u_chk (.*);
`default_nettype wire

// ===== testbench/plb_i2c_mst.sv
// Purpose: Serial bus master standing in for the microcontroller.
// Assumes: SDA open drain with pull-up; SCL phases of 3 clocks or more.
// Notes:   The bench calls the tasks by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module plb_i2c_mst (
    // Clock and bus pins
    input  wire logic i_clk,
    input  wire logic i_sda,
    output var logic  o_scl,
    output var logic  o_sda_low
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic st(input logic c, input logic l, input int n);
        o_scl <= c;
        o_sda_low <= l;
        repeat (n) @(posedge i_clk);
    endtask
    task automatic put_bit(input logic b, output logic r);
        st(1'b0, !b, 3);
        st(1'b1, !b, 2);
        r = i_sda;
        st(1'b1, !b, 2);
        st(1'b0, !b, 1);
    endtask
    task automatic start();
        st(o_scl, 1'b0, 2);
        st(1'b1, 1'b0, 3);
        st(1'b1, 1'b1, 3);
        st(1'b0, 1'b1, 2);
    endtask
    task automatic stop();
        st(1'b0, 1'b1, 3);
        st(1'b1, 1'b1, 3);
        st(1'b1, 1'b0, 3);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                        output logic ack_n);
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], q[i]);
        put_bit(1'b1, ack_n);
    endtask
endmodule
`default_nettype wire

// ===== testbench/plb_bank_tb.sv
// Purpose: Self-checking bench for the parameter bank.
// Assumes: 10 MHz clock; serial bus master model on the pins.
// Notes:   Parameter bytes are random from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module plb_bank_tb;
    import plb_pkg::*;
    logic        clk, rst_n, psel, pen, pwr, nak, scl, m_low;
    logic [7:0]  paddr, rb;
    logic [31:0] pwdata, q;
    logic [4:0]  lc;
    logic [7:0]  tx [0:7];
    logic [7:0]  eb [0:6];
    int          n_errors, comparisons, seed, r, cyc;
    wire logic [31:0] prdata;
    wire logic        pready, irq, oe, lim, hp, ld, mic, dt, ct;
    wire logic [5:0]  sg, rg;
    wire logic [2:0]  dcv;
    wire logic [29:0] oth;
    wire logic        sda = !(oe || m_low);
    wire logic [31:0] fields = {14'h0, sg, lim, rg, hp, ld, dcv};
    wire logic [31:0] route = {29'h0, mic, dt, ct};
    plb_bank u_plb_bank (
        .i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_scl(scl),
        .i_sda(sda), .o_sda_o(oth[29]), .o_sda_oe(oe),
        .i_line_current_code(lc),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(), .o_irq(irq), .o_dc_voltage_sel(dcv),
        .o_fast_dc_start(oth[0]), .o_set_series_res(oth[28:26]),
        .o_set_parallel_res(oth[25:23]), .o_set_pole_freq(oth[22:19]),
        .o_sidetone_series_res(oth[18:15]), .o_sidetone_cap(oth[10:7]),
        .o_sidetone_parallel_res(oth[14:11]), .o_send_gain(sg),
        .o_receive_gain(rg),
        .o_limiter_threshold_sel(lim), .o_hearing_protect_sel(hp),
        .o_earpiece_load_sel(ld), .o_power_down_sel(oth[6:5]),
        .o_ring_detect_disable(oth[4]), .o_receive_mute(oth[3]),
        .o_send_mute(oth[2]), .o_dial_pulse_ctl(oth[1]), .o_mic_path_en(mic),
        .o_dtmf_to_line(dt),
        .o_confidence_tone(ct));
    plb_i2c_mst u_plb_i2c_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_low(m_low));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask
    function automatic logic [31:0] fld(input logic [7:0] b0, b4, b5);
        return {14'h0, b4[5:0], b4[7], b5[5:0], b5[6], b5[7], b0[6:4]};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic check_bank();
        logic [7:0] c;
        c = eb[6];
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(8'h10 + 4 * i), 32'h0);
            chk(q, {24'h0, eb[i]});
        end
        chk(fields, fld(eb[0], eb[4], eb[5]));
        chk(route, {29'h0, !c[2], c[2], &c[3:2]});
        chk({2'h0, oth}, {3'h0, eb[2][2:0], eb[3][6:0],
            eb[1][3:0], eb[1][7:4], eb[2][7:4], eb[6][7:6],
            eb[6][4:2], eb[6][0], eb[0][0]});
    endtask
    task automatic reset_dut();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            eb[i] = PARAM_RESET[i];
        check_bank();
        apb(1'b0, A_STATUS, 32'h0);
        chk(q, {24'h0, 3'h4, lc});
    endtask
    task automatic i2c_wr(input logic [7:0] a, input int s, input int n);
        logic k;
        k = a[7:1] != DEV_ADDR;
        u_plb_i2c_mst.start();
        u_plb_i2c_mst.xfer(a, rb, nak);
        chk(32'(nak), 32'(k));
        u_plb_i2c_mst.xfer(8'(s), rb, nak);
        for (int i = s; i < s + n; i++) begin
            u_plb_i2c_mst.xfer(tx[i], rb, nak);
            chk(32'(nak), 32'(k));
        end
        u_plb_i2c_mst.stop();
    endtask
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        seed = 32'hca70;
        r = $random(seed);
        lc = r[4:0];
        reset_dut();
        apb(1'b0, 8'h40, 32'h0);
        apb(1'b1, A_IRQ_EN, 32'h7);
        for (int i = 0; i < 7; i++) begin
            r = $random(seed);
            tx[i] = r[7:0] & PARAM_MASK[i];
            eb[i] = tx[i];
        end
        tx[7] = 8'h5a;
        i2c_wr(8'h44, 0, 8);
        check_bank();
        apb(1'b0, A_IRQ_STAT, 32'h0);
        chk(q, 32'h5);
        chk({31'h0, irq}, 32'h1);
        for (int m = 0; m < 4; m++) begin
            tx[6] = 8'(m << 2);
            eb[6] = tx[6];
            i2c_wr(8'h44, 6, 1);
            check_bank();
        end
        tx[0] = ~eb[0] & PARAM_MASK[0];
        i2c_wr(8'h46, 0, 1);
        check_bank();
        apb(1'b1, A_IRQ_CLR, 32'h7);
        apb(1'b0, A_IRQ_STAT, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, irq}, 32'h0);
        for (int k = 0; k < 2; k++) begin
            u_plb_i2c_mst.start();
            u_plb_i2c_mst.xfer(8'h45, rb, nak);
            chk(32'(nak), 32'h0);
            u_plb_i2c_mst.xfer(8'hff, rb, nak);
            chk({24'h0, rb}, {24'h0, k == 0, 2'h0, lc});
            u_plb_i2c_mst.stop();
        end
        apb(1'b0, A_IRQ_STAT, 32'h0);
        chk(q, 32'h2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, A_IRQ_EN, 32'h0);
        apb(1'b0, A_STATUS, 32'h0);
        chk(q, {27'h0, lc});
        chk({31'h0, irq}, 32'h0);
        reset_dut();
        give_verdict();
    end
endmodule
`default_nettype wire
